/* File: shared/ssv_pkg.sv */
// shared constants and types of the sync status supervisor
package ssv_pkg;

  // clock and time base
  localparam int CLK_MHZ = 100;
  localparam int MIN_S = 60;
  localparam longint MIN_CYC = longint'(CLK_MHZ) * 64'd1_000_000 *
                               longint'(MIN_S);

  // timer widths and values in minutes
  localparam int TW = 11;
  localparam logic [10:0] BYP_LO = 11'h002;
  localparam logic [10:0] BYP_HI = 11'h5A0;
  localparam logic [10:0] BYP_RST = 11'h002;
  localparam logic [10:0] HOLDOFF_RST = 11'h000;
  localparam logic [10:0] INIT_MIN = 11'h001;
  localparam logic [10:0] RAW_MIN = 11'h00D;

  // ordered status codes, higher is better
  localparam logic [2:0] ST_INVALID = 3'h0;
  localparam logic [2:0] ST_OSC_RESET = 3'h1;
  localparam logic [2:0] ST_HOLD_LOSS = 3'h2;
  localparam logic [2:0] ST_HOLD_OFF = 3'h3;
  localparam logic [2:0] ST_LOCK_SIM = 3'h4;
  localparam logic [2:0] ST_LOCK_BYP = 3'h5;
  localparam logic [2:0] ST_LOCKED = 3'h6;
  localparam logic [2:0] THR_RST = 3'h6;

  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_THR = 8'h04;
  localparam logic [7:0] A_HOLDOFF = 8'h08;
  localparam logic [7:0] A_BYPASS = 8'h0C;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_TIMER = 8'h14;
  localparam logic [7:0] A_ERR = 8'h18;
  localparam logic [7:0] A_IRQ = 8'h1C;
  localparam logic [7:0] A_MASK = 8'h20;

  // control register bits
  localparam int C_TZ = 0;
  localparam int C_DST = 1;
  localparam int C_SIM = 2;
  localparam int C_FACT = 3;
  localparam int C_MRST = 4;
  localparam int C_MSET = 5;

  // live error bits
  localparam int ERR_W = 7;
  localparam int E_TZ = 0;
  localparam int E_DST = 1;
  localparam int E_RAW = 2;
  localparam int E_INIT = 3;
  localparam int E_SHORT = 4;
  localparam int E_OPEN = 5;
  localparam int E_OSC = 6;

  // sticky interrupt bits
  localparam int IRQ_W = 6;
  localparam int I_SHORT = 0;
  localparam int I_OPEN = 1;
  localparam int I_OSC = 2;
  localparam int I_LOSS = 3;
  localparam int I_HOLD = 4;
  localparam int I_LOCK = 5;

  // synchronised pin positions
  localparam int PIN_W = 6;
  localparam int P_LOCK = 0;
  localparam int P_RCV = 1;
  localparam int P_LEAP = 2;
  localparam int P_SHORT = 3;
  localparam int P_OPEN = 4;
  localparam int P_OSC = 5;

  typedef enum logic [2:0] {
    FSM_FREE, FSM_HOLDOFF, FSM_LOCKED, FSM_BYPASS, FSM_HOLDOVER
  } ssv_fsm_t;

  typedef struct packed {
    logic [10:0] left;
    logic done;
  } ssv_tmr_t;

endpackage

/* File: logic/ssv_min_timer.sv */
// minute down counter with load, clear and done pulse
`timescale 1ns/1ps
module ssv_min_timer (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic load_in,
  input wire logic clear_in,
  input wire logic [10:0] val_in,
  input wire logic tick_in,
  output logic busy_out,
  output logic [10:0] left_out,
  output logic done_out
);
  ssv_pkg::ssv_tmr_t st;
  ssv_pkg::ssv_tmr_t next_st;

  // clear beats load, load beats counting
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (clear_in) begin
      next_st.left = '0;
    end else if (load_in) begin
      next_st.left = val_in;
    end else if (tick_in && st.left != '0) begin
      next_st.left = st.left - 11'h001;
      next_st.done = (st.left == 11'h001);
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy_out = (st.left != '0);
  assign left_out = st.left;
  assign done_out = st.done;
endmodule // ssv_min_timer

/* File: logic/ssv_supervisor.sv */
// sync status supervisor with register port, timers and status output
// Operation
// - hold off top status for holdoff minutes after receiver locks
// - on reception loss delay holdover fallback by bypass minutes
// - during bypass report locked-with-bypass status, keep oscillator
// - accept bypass settings only from 2 to 1440 minutes
// - running holdoff or bypass timer remaining value is readable
// - optocoupler on when status at or above threshold, else off
// - seven statuses ranked from locked down to invalid time
// - missing time zone offset flagged, blocks synchronization
// - missing daylight saving data flagged, blocks synchronization
// - after factory default raw mode blocks sync until leap data or 13 minutes with reception
// - summary error high while any module error flag is high
// - receiver initialization shown for at most one minute
// - antenna short flagged when detected
// - antenna open flagged when detected
// - module reset resets hardware state, keeps stored settings
// - oscillator regulation failure flagged
`timescale 1ns/1ps
module ssv_supervisor #(
  parameter logic [32:0] MIN_CYC = 33'(ssv_pkg::MIN_CYC)
) (
  input wire logic MCLK_IN,
  input wire logic NRST_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  input wire logic RCV_LOCK_IN,
  input wire logic RCV_ACTIVE_IN,
  input wire logic LEAP_INFO_IN,
  input wire logic ANT_SHORT_IN,
  input wire logic ANT_OPEN_IN,
  input wire logic OSC_REG_FAIL_IN,
  output logic [2:0] STATUS_OUT,
  output logic OC_OUT,
  output logic SUM_ERR_OUT,
  output logic IRQ_OUT
);
  typedef struct packed {
    logic [ssv_pkg::PIN_W-1:0] s1;
    logic [ssv_pkg::PIN_W-1:0] s2;
    logic [ssv_pkg::PIN_W-1:0] prev;
    logic [32:0] pre;
    logic tick;
    ssv_pkg::ssv_fsm_t fsm;
    logic time_valid;
    logic tz_set;
    logic dst_set;
    logic sim;
    logic [2:0] thr;
    logic [10:0] holdoff;
    logic [10:0] bypass;
    logic [ssv_pkg::IRQ_W-1:0] irq_stat;
    logic [ssv_pkg::IRQ_W-1:0] irq_mask;
    logic [2:0] status;
    logic oc;
    logic sum_err;
    logic irq;
    logic [31:0] rdata;
  } ssv_top_t;

  ssv_top_t st;
  ssv_top_t next_st;

  logic tmr_load;
  logic tmr_clr;
  logic [10:0] tmr_val;
  logic tmr_busy;
  logic [10:0] tmr_left;
  logic tmr_done;
  logic init_load;
  logic init_busy;
  logic raw_load;
  logic raw_clr;
  logic raw_tick;
  logic raw_busy;
  logic [ssv_pkg::ERR_W-1:0] err_live;
  logic sync_ok;
  logic wr_ctrl;
  logic fact;
  logic mrst;

  // shared holdoff and bypass timer, only one runs at a time
  ssv_min_timer u_main_tmr (
    .clk_in(MCLK_IN),
    .nrst_in(NRST_IN),
    .load_in(tmr_load),
    .clear_in(tmr_clr),
    .val_in(tmr_val),
    .tick_in(st.tick),
    .busy_out(tmr_busy),
    .left_out(tmr_left),
    .done_out(tmr_done)
  );

  // receiver initialization window
  ssv_min_timer u_init_tmr (
    .clk_in(MCLK_IN),
    .nrst_in(NRST_IN),
    .load_in(init_load),
    .clear_in(1'b0),
    .val_in(ssv_pkg::INIT_MIN),
    .tick_in(st.tick),
    .busy_out(init_busy),
    .left_out(),
    .done_out()
  );

  // raw data window, counts only minutes with reception
  ssv_min_timer u_raw_tmr (
    .clk_in(MCLK_IN),
    .nrst_in(NRST_IN),
    .load_in(raw_load),
    .clear_in(raw_clr),
    .val_in(ssv_pkg::RAW_MIN),
    .tick_in(raw_tick),
    .busy_out(raw_busy),
    .left_out(),
    .done_out()
  );

  // whole next state of the block
  always_comb begin
    next_st = st;
    tmr_load = 1'b0;
    tmr_clr = 1'b0;
    tmr_val = '0;
    init_load = 1'b0;
    raw_load = 1'b0;
    raw_clr = 1'b0;
    raw_tick = 1'b0;
    err_live = '0;
    sync_ok = 1'b0;

    // two-stage pin synchronisers
    next_st.s1 = {OSC_REG_FAIL_IN, ANT_OPEN_IN, ANT_SHORT_IN,
                  LEAP_INFO_IN, RCV_ACTIVE_IN, RCV_LOCK_IN};
    next_st.s2 = st.s1;
    next_st.prev = st.s2;

    // minute prescaler
    next_st.tick = (st.pre == '0);
    next_st.pre = (st.pre == '0) ? MIN_CYC - 33'h0_0000_0001
                                 : st.pre - 33'h0_0000_0001;

    wr_ctrl = WR_IN && (ADDR_IN == ssv_pkg::A_CTRL);
    fact = wr_ctrl && WDATA_IN[ssv_pkg::C_FACT];
    mrst = fact || (wr_ctrl && WDATA_IN[ssv_pkg::C_MRST]);

    // register writes
    if (wr_ctrl) begin
      next_st.tz_set = WDATA_IN[ssv_pkg::C_TZ];
      next_st.dst_set = WDATA_IN[ssv_pkg::C_DST];
      next_st.sim = WDATA_IN[ssv_pkg::C_SIM];
      if (WDATA_IN[ssv_pkg::C_MSET]) begin
        next_st.time_valid = 1'b1;
      end
    end else if (WR_IN && ADDR_IN == ssv_pkg::A_THR) begin
      next_st.thr = WDATA_IN[2:0];
    end else if (WR_IN && ADDR_IN == ssv_pkg::A_HOLDOFF) begin
      next_st.holdoff = WDATA_IN[10:0];
    end else if (WR_IN && ADDR_IN == ssv_pkg::A_BYPASS) begin
      if (WDATA_IN >= 32'(ssv_pkg::BYP_LO) &&
          WDATA_IN <= 32'(ssv_pkg::BYP_HI)) begin
        next_st.bypass = WDATA_IN[10:0];
      end
    end else if (WR_IN && ADDR_IN == ssv_pkg::A_MASK) begin
      next_st.irq_mask = WDATA_IN[ssv_pkg::IRQ_W-1:0];
    end

    // live module errors
    // time zone missing
    err_live[ssv_pkg::E_TZ] = !st.tz_set;
    err_live[ssv_pkg::E_DST] = !st.dst_set;
    err_live[ssv_pkg::E_RAW] = raw_busy;
    err_live[ssv_pkg::E_INIT] = init_busy;
    err_live[ssv_pkg::E_SHORT] = st.s2[ssv_pkg::P_SHORT];
    err_live[ssv_pkg::E_OPEN] = st.s2[ssv_pkg::P_OPEN];
    err_live[ssv_pkg::E_OSC] = st.s2[ssv_pkg::P_OSC];

    sync_ok = st.s2[ssv_pkg::P_LOCK] && st.tz_set && st.dst_set &&
              !raw_busy && !init_busy;

    // raw window runs only on minutes with reception, ends on leap data
    raw_tick = st.tick && st.s2[ssv_pkg::P_RCV];
    raw_clr = st.s2[ssv_pkg::P_LEAP];

    // synchronization state machine
    case (st.fsm)
      ssv_pkg::FSM_FREE, ssv_pkg::FSM_HOLDOVER: begin
        if (sync_ok && st.holdoff == '0) begin
          next_st.fsm = ssv_pkg::FSM_LOCKED;
        end else if (sync_ok) begin
          tmr_load = 1'b1;
          tmr_val = st.holdoff;
          next_st.fsm = ssv_pkg::FSM_HOLDOFF;
        end
      end
      ssv_pkg::FSM_HOLDOFF: begin
        if (!sync_ok) begin
          tmr_clr = 1'b1;
          next_st.fsm = ssv_pkg::FSM_HOLDOVER;
        end else if (tmr_done) begin
          next_st.fsm = ssv_pkg::FSM_LOCKED;
        end
      end
      ssv_pkg::FSM_LOCKED: begin
        if (!sync_ok) begin
          tmr_load = 1'b1;
          tmr_val = st.bypass;
          next_st.fsm = ssv_pkg::FSM_BYPASS;
        end
      end
      ssv_pkg::FSM_BYPASS: begin
        if (sync_ok) begin
          tmr_clr = 1'b1;
          next_st.fsm = ssv_pkg::FSM_LOCKED;
        end else if (tmr_done) begin
          next_st.fsm = ssv_pkg::FSM_HOLDOVER;
        end
      end
      default: begin
        next_st.fsm = ssv_pkg::FSM_FREE;
      end
    endcase
    if (next_st.fsm == ssv_pkg::FSM_LOCKED) begin
      next_st.time_valid = 1'b1;
    end

    if (mrst) begin
      next_st.fsm = ssv_pkg::FSM_FREE;
      tmr_load = 1'b0;
      tmr_clr = 1'b1;
      init_load = 1'b1;
    end
    if (fact) begin
      raw_load = 1'b1;
      raw_clr = 1'b0;
      next_st.tz_set = 1'b0;
      next_st.dst_set = 1'b0;
      next_st.sim = 1'b0;
      next_st.time_valid = 1'b0;
      next_st.thr = ssv_pkg::THR_RST;
      next_st.holdoff = ssv_pkg::HOLDOFF_RST;
      next_st.bypass = ssv_pkg::BYP_RST;
    end

    case (st.fsm)
      ssv_pkg::FSM_LOCKED: next_st.status = ssv_pkg::ST_LOCKED;
      ssv_pkg::FSM_BYPASS: next_st.status = ssv_pkg::ST_LOCK_BYP;
      ssv_pkg::FSM_HOLDOFF: next_st.status = ssv_pkg::ST_HOLD_OFF;
      ssv_pkg::FSM_HOLDOVER: begin
        next_st.status = st.sim ? ssv_pkg::ST_LOCK_SIM
                                : ssv_pkg::ST_HOLD_LOSS;
      end
      default: begin
        if (st.sim) begin
          next_st.status = ssv_pkg::ST_LOCK_SIM;
        end else if (st.time_valid) begin
          next_st.status = ssv_pkg::ST_OSC_RESET;
        end else begin
          next_st.status = ssv_pkg::ST_INVALID;
        end
      end
    endcase

    next_st.oc = (st.status >= st.thr);
    next_st.sum_err = |err_live;

    // sticky events, a new event wins over the write-one clear
    if (WR_IN && ADDR_IN == ssv_pkg::A_IRQ) begin
      next_st.irq_stat = st.irq_stat & ~WDATA_IN[ssv_pkg::IRQ_W-1:0];
    end
    next_st.irq_stat[ssv_pkg::I_SHORT] |= st.s2[ssv_pkg::P_SHORT] &&
                                          !st.prev[ssv_pkg::P_SHORT];
    next_st.irq_stat[ssv_pkg::I_OPEN] |= st.s2[ssv_pkg::P_OPEN] &&
                                         !st.prev[ssv_pkg::P_OPEN];
    next_st.irq_stat[ssv_pkg::I_OSC] |= st.s2[ssv_pkg::P_OSC] &&
                                        !st.prev[ssv_pkg::P_OSC];
    next_st.irq_stat[ssv_pkg::I_LOSS] |=
      st.fsm == ssv_pkg::FSM_LOCKED && next_st.fsm == ssv_pkg::FSM_BYPASS;
    next_st.irq_stat[ssv_pkg::I_HOLD] |=
      st.fsm == ssv_pkg::FSM_BYPASS && next_st.fsm == ssv_pkg::FSM_HOLDOVER;
    next_st.irq_stat[ssv_pkg::I_LOCK] |=
      st.fsm != ssv_pkg::FSM_BYPASS && st.fsm != ssv_pkg::FSM_LOCKED &&
      next_st.fsm == ssv_pkg::FSM_LOCKED;
    next_st.irq = |(st.irq_stat & st.irq_mask);

    // read data stands for one cycle only
    next_st.rdata = '0;
    if (RD_IN) begin
      if (ADDR_IN == ssv_pkg::A_CTRL) begin
        next_st.rdata = {29'h0000_0000, st.sim, st.dst_set, st.tz_set};
      end else if (ADDR_IN == ssv_pkg::A_THR) begin
        next_st.rdata = {29'h0000_0000, st.thr};
      end else if (ADDR_IN == ssv_pkg::A_HOLDOFF) begin
        next_st.rdata = {21'h00_0000, st.holdoff};
      end else if (ADDR_IN == ssv_pkg::A_BYPASS) begin
        next_st.rdata = {21'h00_0000, st.bypass};
      end else if (ADDR_IN == ssv_pkg::A_STATUS) begin
        next_st.rdata = {24'h00_0000, 1'b0, st.fsm, st.status, st.oc};
      end else if (ADDR_IN == ssv_pkg::A_TIMER) begin
        next_st.rdata = {20'h0_0000, tmr_busy, tmr_left};
      end else if (ADDR_IN == ssv_pkg::A_ERR) begin
        next_st.rdata = {25'h000_0000, err_live};
      end else if (ADDR_IN == ssv_pkg::A_IRQ) begin
        next_st.rdata = {26'h000_0000, st.irq_stat};
      end else if (ADDR_IN == ssv_pkg::A_MASK) begin
        next_st.rdata = {26'h000_0000, st.irq_mask};
      end
    end
  end

  // state register with reset values
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      st <= '0;
      st.fsm <= ssv_pkg::FSM_FREE;
      st.thr <= ssv_pkg::THR_RST;
      st.holdoff <= ssv_pkg::HOLDOFF_RST;
      st.bypass <= ssv_pkg::BYP_RST;
      st.status <= ssv_pkg::ST_INVALID;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign RDATA_OUT = st.rdata;
  assign STATUS_OUT = st.status;
  assign OC_OUT = st.oc;
  assign SUM_ERR_OUT = st.sum_err;
  assign IRQ_OUT = st.irq;

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!NRST_IN);

  a_holdoff_blocks_lock: assert property (
    st.fsm == ssv_pkg::FSM_HOLDOFF && tmr_busy && !mrst
    |=> st.fsm == ssv_pkg::FSM_HOLDOFF || st.fsm == ssv_pkg::FSM_HOLDOVER)
    else $error("locked before holdoff expired");

  a_loss_to_bypass: assert property (
    st.fsm == ssv_pkg::FSM_LOCKED && !sync_ok && !mrst
    |=> st.fsm == ssv_pkg::FSM_BYPASS && tmr_left == $past(st.bypass))
    else $error("loss did not start bypass");

  a_bypass_status: assert property (
    st.fsm == ssv_pkg::FSM_BYPASS ##1 st.fsm == ssv_pkg::FSM_BYPASS
    |-> STATUS_OUT == ssv_pkg::ST_LOCK_BYP)
    else $error("bypass status wrong");

  a_bypass_range: assert property (
    WR_IN && ADDR_IN == ssv_pkg::A_BYPASS &&
    (WDATA_IN < 32'h0000_0002 || WDATA_IN > 32'h0000_05A0) && !fact
    |=> $stable(st.bypass))
    else $error("bad bypass value accepted");

  a_timer_read: assert property (
    RD_IN && ADDR_IN == ssv_pkg::A_TIMER
    |=> RDATA_OUT[10:0] == $past(tmr_left) && RDATA_OUT[11] == $past(tmr_busy))
    else $error("timer readback wrong");

  a_oc_compare: assert property (
    1'b1 |=> OC_OUT == ($past(STATUS_OUT) >= $past(st.thr)))
    else $error("optocoupler compare wrong");

  a_sync_blocked: assert property (
    (!st.tz_set || !st.dst_set || raw_busy) && !fact
    |=> st.fsm != ssv_pkg::FSM_HOLDOFF && !$rose(st.fsm == ssv_pkg::FSM_LOCKED))
    else $error("sync while configuration missing");

  a_sum_err: assert property (
    1'b1 |=> SUM_ERR_OUT == $past(|err_live))
    else $error("summary error mismatch");

  a_short_irq: assert property (
    $rose(st.s2[ssv_pkg::P_SHORT]) |=> st.irq_stat[ssv_pkg::I_SHORT])
    else $error("antenna short not flagged");

  a_mrst_keep: assert property (
    mrst && !fact |=> $stable(st.holdoff) && $stable(st.bypass) &&
                      st.fsm == ssv_pkg::FSM_FREE && init_busy)
    else $error("module reset lost settings");
endmodule // ssv_supervisor

/* File: verif/ssv_rcv_model.sv */
// behavioural satellite receiver driving the supervisor link pins
`timescale 1ns/1ps
module ssv_rcv_model (
  input wire logic clk_in,
  input wire logic lock_req_in,
  input wire logic act_req_in,
  input wire logic leap_req_in,
  input wire logic [2:0] flt_req_in,
  input wire logic [3:0] lag_in,
  output logic lock_out,
  output logic act_out,
  output logic leap_out,
  output logic short_out,
  output logic open_out,
  output logic osc_fail_out
);
  // lock history, so lock changes may arrive late
  logic [15:0] hist = 16'h0000;
  always @(posedge clk_in) begin
    hist <= {hist[14:0], lock_req_in};
  end
  // lock after the chosen lag, other pins follow at once
  assign lock_out = hist[lag_in];
  assign act_out = act_req_in;
  assign leap_out = leap_req_in;
  assign short_out = flt_req_in[0];
  assign open_out = flt_req_in[1];
  assign osc_fail_out = flt_req_in[2];
endmodule // ssv_rcv_model

/* File: verif/tb.sv */
// self-checking bench for the sync status supervisor
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic lock_req = 1'b0;
  logic act_req = 1'b1;
  logic leap_req = 1'b0;
  logic [2:0] flt_req = 3'h0;
  logic [3:0] lag = 4'h0;
  logic [31:0] rdata;
  logic [2:0] status;
  logic oc, sum_err, irq;
  logic r_lock, r_act, r_leap, a_short, a_open, o_fail;
  logic [31:0] v;
  logic [10:0] byp_now;
  logic [10:0] bv [8];
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  localparam int TB_MIN = 20;

  // 100 MHz clock
  always #5 mclk = ~mclk;

  // cycles since reset release, minute ticks land where cyc is 2 mod TB_MIN
  always @(posedge mclk) begin
    cyc <= nrst ? cyc + 1 : 0;
  end

  ssv_supervisor #(.MIN_CYC(33'(TB_MIN))) ssv_supervisor_inst (
    .MCLK_IN(mclk), .NRST_IN(nrst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .RCV_LOCK_IN(r_lock),
    .RCV_ACTIVE_IN(r_act), .LEAP_INFO_IN(r_leap), .ANT_SHORT_IN(a_short),
    .ANT_OPEN_IN(a_open), .OSC_REG_FAIL_IN(o_fail), .STATUS_OUT(status),
    .OC_OUT(oc), .SUM_ERR_OUT(sum_err), .IRQ_OUT(irq));

  ssv_rcv_model ssv_rcv_model_inst (
    .clk_in(mclk), .lock_req_in(lock_req), .act_req_in(act_req),
    .leap_req_in(leap_req), .flt_req_in(flt_req), .lag_in(lag),
    .lock_out(r_lock), .act_out(r_act), .leap_out(r_leap),
    .short_out(a_short), .open_out(a_open), .osc_fail_out(o_fail));

  // expected optocoupler level
  function automatic logic exp_oc(input logic [2:0] st, input logic [2:0] t);
    return st >= t;
  endfunction

  // expected bypass setting after a write
  function automatic logic [10:0] byp_exp(input logic [10:0] o,
                                          input logic [10:0] n);
    if (n >= ssv_pkg::BYP_LO && n <= ssv_pkg::BYP_HI) begin
      return n;
    end
    return o;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] m, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    v = rdata;
    chk(nm, e & m, v & m);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // return just after a minute tick, so a fresh one-minute window stays up
  task automatic after_tick();
    do begin
      @(posedge mclk);
      #1;
    end while (cyc % TB_MIN != 2);
  endtask

  task automatic wait_st(input logic [2:0] e, input int n);
    int i;
    i = 0;
    #1;
    while (status !== e && i < n) begin
      @(posedge mclk);
      #1;
      i++;
    end
    chk("status", 32'(e), 32'(status));
  endtask

  task automatic tally_and_finish();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // watchdog well beyond the fewer than nine hundred cycles the tests need
  initial begin
    #(20000 * 10);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    v = $urandom(32'h08fb);
    bv = '{11'h001, 11'h5a1, 11'h7ff, 11'h000, 11'h5a0, 11'h002, 11'h002,
           11'h003};
    bv[6] = 11'(ssv_pkg::BYP_LO + ($urandom % 1439));
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    step(2);
    // reset values and unmapped place
    rc("thr", ssv_pkg::A_THR, 32'h0000_0007, 32'h0000_0006);
    rc("holdoff", ssv_pkg::A_HOLDOFF, 32'h0000_07ff, 32'h0);
    rc("bypass", ssv_pkg::A_BYPASS, 32'h0000_07ff, 32'h2);
    rc("mask", ssv_pkg::A_MASK, 32'hffff_ffff, 32'h0);
    rc("unmapped", 8'h24, 32'hffff_ffff, 32'h0);
    rc("err", ssv_pkg::A_ERR, 32'h0000_007f, 32'h3);
    chk("sum_err", 32'h1, 32'(sum_err));
    // missing offset or changeover data blocks sync
    @(posedge mclk);
    lock_req <= 1'b1;
    step(20);
    chk("status", 32'h0, 32'(status));
    wr_reg(ssv_pkg::A_CTRL, 32'h0000_0001);
    step(20);
    chk("status", 32'h0, 32'(status));
    wr_reg(ssv_pkg::A_CTRL, 32'h0000_0003);
    wait_st(ssv_pkg::ST_LOCKED, 12);
    chk("sum_err", 32'h0, 32'(sum_err));
    // bypass range, refused values leave the setting alone
    byp_now = ssv_pkg::BYP_RST;
    foreach (bv[i]) begin
      wr_reg(ssv_pkg::A_BYPASS, 32'(bv[i]));
      byp_now = byp_exp(byp_now, bv[i]);
      rc("bypass", ssv_pkg::A_BYPASS, 32'h7ff, 32'(byp_now));
    end
    // optocoupler against every threshold
    for (int t = 0; t < 8; t++) begin
      wr_reg(ssv_pkg::A_THR, 32'(t));
      step(3);
      chk("oc", 32'(exp_oc(ssv_pkg::ST_LOCKED, 3'(t))),
          32'(oc));
    end
    // reception loss, bypass then holdover
    wr_reg(ssv_pkg::A_THR, 32'h0000_0005);
    lock_req <= 1'b0;
    wait_st(ssv_pkg::ST_LOCK_BYP, 12);
    step(2);
    chk("oc", 32'h1, 32'(oc));
    rc("tmr run", ssv_pkg::A_TIMER, 32'h0000_0800, 32'h800);
    chk("tmr val", 32'h1,
        32'(v[10:0] >= 11'h001 && v[10:0] <= 11'h003));
    step(20);
    chk("status", 32'(ssv_pkg::ST_LOCK_BYP), 32'(status));
    wait_st(ssv_pkg::ST_HOLD_LOSS, 50);
    step(2);
    chk("oc", 32'h0, 32'(oc));
    wr_reg(ssv_pkg::A_CTRL, 32'h0000_0007);
    wait_st(ssv_pkg::ST_LOCK_SIM, 8);
    wr_reg(ssv_pkg::A_CTRL, 32'h0000_0003);
    wait_st(ssv_pkg::ST_HOLD_LOSS, 8);
    // holdoff before the top status, lock arriving late
    wr_reg(ssv_pkg::A_HOLDOFF, 32'h0000_0002);
    lag <= 4'($urandom % 8);
    lock_req <= 1'b1;
    wait_st(ssv_pkg::ST_HOLD_OFF, 16);
    rc("tmr run", ssv_pkg::A_TIMER, 32'h0000_0800, 32'h800);
    step(10);
    chk("status", 32'(ssv_pkg::ST_HOLD_OFF), 32'(status));
    wait_st(ssv_pkg::ST_LOCKED, 50);
    wr_reg(ssv_pkg::A_HOLDOFF, 32'h0000_0000);
    // antenna and oscillator faults, flags and interrupts
    wr_reg(ssv_pkg::A_IRQ, 32'h0000_003f);
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      flt_req <= 3'(1 << i);
      step(5);
      rc("err", ssv_pkg::A_ERR, 32'h7f,
         32'(1 << (ssv_pkg::E_SHORT + i)));
      chk("sum_err", 32'h1, 32'(sum_err));
      rc("irq", ssv_pkg::A_IRQ, 32'h7, 32'(1 << i));
      chk("irq masked", 32'h0, 32'(irq));
      wr_reg(ssv_pkg::A_MASK, 32'(1 << i));
      step(2);
      chk("irq", 32'h1, 32'(irq));
      @(posedge mclk);
      flt_req <= 3'h0;
      wr_reg(ssv_pkg::A_IRQ, 32'(1 << i));
      step(3);
      chk("irq", 32'h0, 32'(irq));
      chk("sum_err", 32'h0, 32'(sum_err));
      wr_reg(ssv_pkg::A_MASK, 32'h0000_0000);
    end
    // module reset keeps the settings
    // start the init window right after a tick so it is seen set
    after_tick();
    wr_reg(ssv_pkg::A_CTRL, 32'h0000_0013);
    rc("err", ssv_pkg::A_ERR, 32'h7f, 32'h8);
    rc("thr", ssv_pkg::A_THR, 32'h7, 32'h5);
    rc("bypass", ssv_pkg::A_BYPASS, 32'h7ff, 32'h3);
    step(25);
    rc("err", ssv_pkg::A_ERR, 32'h7f, 32'h0);
    wait_st(ssv_pkg::ST_LOCKED, 30);
    // factory default, raw mode until leap data
    after_tick();
    wr_reg(ssv_pkg::A_CTRL, 32'h0000_0008);
    rc("err", ssv_pkg::A_ERR, 32'h7f, 32'hf);
    rc("thr", ssv_pkg::A_THR, 32'h7, 32'h6);
    rc("bypass", ssv_pkg::A_BYPASS, 32'h7ff, 32'h2);
    wr_reg(ssv_pkg::A_CTRL, 32'h0000_0020);
    wait_st(ssv_pkg::ST_OSC_RESET, 8);
    wr_reg(ssv_pkg::A_CTRL, 32'h0000_0003);
    // no reception: the raw window must not run out on its own
    act_req <= 1'b0;
    step(300);
    chk("raw status", 32'(ssv_pkg::ST_OSC_RESET), 32'(status));
    rc("err", ssv_pkg::A_ERR, 32'h7f, 32'h4);
    @(posedge mclk);
    act_req <= 1'b1;
    leap_req <= 1'b1;
    wait_st(ssv_pkg::ST_LOCKED, 30);
    rc("err", ssv_pkg::A_ERR, 32'h7f, 32'h0);
    tally_and_finish();
  end
endmodule // tb
